//--- rtl/alarm_supervisor_consts.svh
`ifndef ALARM_SUPERVISOR_CONSTS_SVH
`define ALARM_SUPERVISOR_CONSTS_SVH
`define CLK_HZ            200000000
`define TICK_SEC          1
`define TICK_CYCLES       (`CLK_HZ * `TICK_SEC)
`define SEC_PER_MIN       60
`define A_CTRL            8'h00
`define A_T1              8'h04
`define A_T2              8'h08
`define A_SOFT            8'h0C
`define A_LOOP            8'h10
`define A_SAFE            8'h14
`define A_MAN             8'h18
`define A_RETX            8'h1C
`define A_BAND            8'h20
`define A_STAT            8'h24
`define B_RUN             0
`define B_MANUAL          1
`define B_RSP             2
`define B_RETX_SP         3
`define B_RETX_420        4
`define B_BLOCK           8
`define B_SBRK            12
`define PCT_FULL          10'd1000
`define MA4_CODE          16'd13107
`define MA_FULL           16'hFFFF
`define PV_DELTA          16'h0010
`endif

//--- rtl/alarm_supervisor_pkg.sv
package alarm_supervisor_pkg;
  typedef logic [9:0]  pct_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    BLK_IDLE  = 3'b001,
    BLK_WAIT  = 3'b010,
    BLK_ARMED = 3'b100
  } blk_e;
endpackage

//--- rtl/alarm_output_supervisor.sv
`timescale 1ns/1ps
`include "alarm_supervisor_consts.svh"

//Overview of operation
// - two timers: follow, pulse, delay, intermittent
// - lamp follows raw alarm condition
// - initial blocking ignores condition present at power-up
// - blocked alarm arms after condition clears once
// - sensor-break alarm never blocked
// - mode selects computed or manual power
// - output 1 full PID, output 2 proportional
// - zero band gives output 1 on/off
// - overlap, dead band or neither at SP
// - run negated holds alarm, power and loop-break outputs off
// - run asserted lets outputs switch freely
// - stopped display alternates stop and PV
// - soft-start ramp limits output power
// - zero soft-start time disables ramp
// - remote setpoint by input or parameter
// - retransmission scales PV or SP linearly
// - no PV response in interval flags break
// - loop-break channel active during break
// - zero interval disables loop-break
// - sensor failure forces safe MV1
// - zero safe value switches output off
module alarm_output_supervisor #(
  parameter int NALM = 4,
  parameter int TICK_CYC = `TICK_CYCLES
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [7:0]                   haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [NALM-1:0]              alarm_cond,
  input  wire logic                         sensor_fail,
  input  wire logic                         run_switch_closed,
  input  wire logic                         remote_setpoint_select_input,
  input  wire alarm_supervisor_pkg::word_t  pv,
  input  wire alarm_supervisor_pkg::word_t  sp_main,
  input  wire alarm_supervisor_pkg::word_t  sp_remote,
  input  wire alarm_supervisor_pkg::pct_t   pid_mv1,
  input  wire alarm_supervisor_pkg::pct_t   prop_mv2,
  input  wire logic                         pv_above_sp,
  input  wire alarm_supervisor_pkg::word_t  deviation,
  output logic [NALM-1:0]                   alarm_out,
  output logic [NALM-1:0]                   alarm_lamp,
  output alarm_supervisor_pkg::pct_t        mv1_out,
  output alarm_supervisor_pkg::pct_t        mv2_out,
  output logic                              loop_break_out,
  output logic                              loop_break_flag,
  output logic                              display_stop,
  output alarm_supervisor_pkg::word_t       sp_active,
  output alarm_supervisor_pkg::word_t       retx_code
);
  import alarm_supervisor_pkg::*;

  typedef struct packed {
    logic [31:0]           tick_cnt;
    logic                  tick;
    logic [31:0]           ctrl;
    logic [31:0]           t1;
    logic [31:0]           t2;
    logic [15:0]           soft_sec;
    logic [15:0]           loop_min;
    pct_t                  safe;
    pct_t                  man1;
    pct_t                  man2;
    logic [31:0]           retx_rng;
    logic [15:0]           band;
    logic [15:0]           overlap;
    logic                  dph;
    logic [7:0]            daddr;
    logic                  dwr;
    logic [31:0]           rdata;
    logic [NALM*3-1:0]     blk;
    logic [NALM-1:0]       cond_q;
    logic [NALM*13-1:0]    tmr;
    logic [NALM-1:0]       outv;
    logic [NALM-1:0]       lamp;
    logic [15:0]           soft_cnt;
    logic [21:0]           lb_cnt;
    word_t                 lb_pv;
    logic                  lb;
    logic                  blink;
    logic                  dstop;
    pct_t                  mv1;
    pct_t                  mv2;
    word_t                 spa;
    word_t                 retx;
  } st_s;

  st_s st_r;
  st_s st_nxt;

  function automatic pct_t clamp_min(input pct_t a, input pct_t b);
    clamp_min = (a < b) ? a : b;
  endfunction

  function automatic word_t scale(input word_t v, input word_t lo, input word_t hi, input logic f420);
    logic [31:0] num;
    logic [15:0] span;
    logic [15:0] base;
    logic [31:0] q;
    span = hi - lo;
    base = f420 ? `MA4_CODE : 16'h0000;
    num = 32'h0000_0000;
    q = 32'h0000_0000;
    if (v <= lo || span == 16'h0000) begin
      scale = base;
    end else if (v >= hi) begin
      scale = `MA_FULL;
    end else begin
      num = 32'(v - lo) * 32'(`MA_FULL - base);
      q = num / 32'(span);
      scale = 16'(32'(base) + q);
    end
  endfunction

  wire logic run = st_r.ctrl[`B_RUN] & run_switch_closed;
  logic [15:0] sec_per_pct;

  always_comb begin
    st_nxt = st_r;
    sec_per_pct = 16'h0000;
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt >= 32'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
    end
    // ahb-lite slave, zero wait, always okay
    st_nxt.dph = hsel & hready & htrans[1];
    if (hsel & hready & htrans[1]) begin
      st_nxt.daddr = haddr;
      st_nxt.dwr = hwrite;
    end
    if (st_r.dph & st_r.dwr) begin
      case (st_r.daddr)
        `A_CTRL: st_nxt.ctrl = hwdata;
        `A_T1:   st_nxt.t1 = hwdata;
        `A_T2:   st_nxt.t2 = hwdata;
        `A_SOFT: st_nxt.soft_sec = hwdata[15:0];
        `A_LOOP: st_nxt.loop_min = hwdata[15:0];
        `A_SAFE: st_nxt.safe = hwdata[9:0];
        `A_MAN: begin
          st_nxt.man1 = hwdata[9:0];
          st_nxt.man2 = hwdata[25:16];
        end
        `A_RETX: st_nxt.retx_rng = hwdata;
        `A_BAND: begin
          st_nxt.band = hwdata[15:0];
          st_nxt.overlap = hwdata[31:16];
        end
        default: ;
      endcase
    end
    if (hsel & hready & htrans[1] & ~hwrite) begin
      case (haddr)
        `A_CTRL: st_nxt.rdata = st_r.ctrl;
        `A_T1:   st_nxt.rdata = st_r.t1;
        `A_T2:   st_nxt.rdata = st_r.t2;
        `A_SOFT: st_nxt.rdata = {16'h0000, st_r.soft_sec};
        `A_LOOP: st_nxt.rdata = {16'h0000, st_r.loop_min};
        `A_SAFE: st_nxt.rdata = {22'h000000, st_r.safe};
        `A_MAN:  st_nxt.rdata = {6'h00, st_r.man2, 6'h00, st_r.man1};
        `A_RETX: st_nxt.rdata = st_r.retx_rng;
        `A_BAND: st_nxt.rdata = {st_r.overlap, st_r.band};
        `A_STAT: st_nxt.rdata = {22'h000000, st_r.lb, run, 4'(st_r.lamp), 4'(st_r.outv)};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    for (int i = 0; i < NALM; i++) begin
      logic c;
      logic [12:0] a;
      logic [12:0] b;
      logic [12:0] t;
      logic rec;
      blk_e bs;
      c = alarm_cond[i];
      a = st_r.t1[i*8 +: 8] == 8'h00 ? 13'h0000 : 13'(st_r.t1[i*8 +: 8]) * 13'h0019;
      b = st_r.t2[i*8 +: 8] == 8'h00 ? 13'h0000 : 13'(st_r.t2[i*8 +: 8]) * 13'h0019;
      t = st_r.tmr[i*13 +: 13];
      bs = blk_e'(st_r.blk[i*3 +: 3]);
      rec = 1'b0;
      st_nxt.lamp[i] = c;
      case (bs)
        BLK_IDLE: begin
          // decide at first run after reset, once the block bits are loaded
          if (!run) begin
            bs = BLK_IDLE;
          end else if (st_r.ctrl[`B_BLOCK+i] & ~st_r.ctrl[`B_SBRK+i] & c) begin
            bs = BLK_WAIT;
          end else begin
            bs = BLK_ARMED;
          end
        end
        BLK_WAIT: begin
          if (~c) begin
            bs = BLK_ARMED;
          end
        end
        BLK_ARMED: rec = c;
        default: bs = BLK_ARMED;
      endcase
      st_nxt.blk[i*3 +: 3] = 3'(bs);
      if (rec & ~st_r.cond_q[i]) begin
        t = 13'h0000;
      end else if (rec & st_r.tick & (t != 13'h1FFF)) begin
        t = t + 13'h0001;
      end
      st_nxt.cond_q[i] = rec;
      st_nxt.tmr[i*13 +: 13] = t;
      if (!rec) begin
        st_nxt.outv[i] = 1'b0;
      end else if (a == 13'h0000 && b == 13'h0000) begin
        st_nxt.outv[i] = 1'b1;
      end else if (b == 13'h0000) begin
        st_nxt.outv[i] = t < a;
      end else if (a == 13'h0000) begin
        st_nxt.outv[i] = t >= b;
      end else begin
        st_nxt.outv[i] = (t % (a + b)) < a;
        if (t >= a + b) begin
          st_nxt.tmr[i*13 +: 13] = (rec & st_r.tick) ? 13'h0001 : 13'h0000;
        end
      end
      if (!run) begin
        st_nxt.outv[i] = 1'b0;
      end
    end

    st_nxt.spa = (st_r.ctrl[`B_RSP] | remote_setpoint_select_input) ? sp_remote : sp_main;

    if (!run) begin
      st_nxt.soft_cnt = 16'h0000;
    end else if (st_r.tick && st_r.soft_cnt != 16'hFFFF) begin
      st_nxt.soft_cnt = st_r.soft_cnt + 16'h0001;
    end

    if (st_r.ctrl[`B_MANUAL]) begin
      st_nxt.mv1 = st_r.man1;
      st_nxt.mv2 = st_r.man2;
    end else begin
      if (st_r.band == 16'h0000) begin
        st_nxt.mv1 = pv_above_sp ? 10'd0 : `PCT_FULL;
      end else begin
        st_nxt.mv1 = pid_mv1;
      end
      st_nxt.mv2 = prop_mv2;
      if ($signed(st_r.overlap) <= 0) begin
        if (!pv_above_sp || deviation <= 16'(-$signed(st_r.overlap))) begin
          st_nxt.mv2 = 10'd0;
        end
        if (pv_above_sp || deviation == 16'h0000) begin
          st_nxt.mv1 = 10'd0;
        end
      end else if (pv_above_sp && deviation > st_r.overlap) begin
        st_nxt.mv1 = 10'd0;
      end
    end
    if (st_r.soft_sec != 16'h0000 && st_r.soft_cnt < st_r.soft_sec) begin
      sec_per_pct = 16'(32'(st_r.soft_cnt) * 32'(`PCT_FULL) / 32'(st_r.soft_sec));
      st_nxt.mv1 = clamp_min(st_nxt.mv1, sec_per_pct[9:0]);
      st_nxt.mv2 = clamp_min(st_nxt.mv2, sec_per_pct[9:0]);
    end
    if (sensor_fail) begin
      st_nxt.mv1 = st_r.safe;
    end
    if (!run) begin
      st_nxt.mv1 = 10'd0;
      st_nxt.mv2 = 10'd0;
    end

    if (st_r.loop_min == 16'h0000 || !run) begin
      st_nxt.lb_cnt = 22'h000000;
      st_nxt.lb = 1'b0;
      st_nxt.lb_pv = pv;
    end else if (st_r.mv1 == 10'd0 || (pv - st_r.lb_pv) >= `PV_DELTA && (st_r.lb_pv - pv) >= `PV_DELTA) begin
      st_nxt.lb_cnt = 22'h000000;
      st_nxt.lb = 1'b0;
      st_nxt.lb_pv = pv;
    end else if (st_r.tick) begin
      if (st_r.lb_cnt >= 22'(32'(st_r.loop_min) * `SEC_PER_MIN)) begin
        st_nxt.lb = 1'b1;
      end else begin
        st_nxt.lb_cnt = st_r.lb_cnt + 22'h000001;
      end
    end

    if (st_r.tick) begin
      st_nxt.blink = ~st_r.blink;
    end
    st_nxt.dstop = ~run & st_nxt.blink;
    st_nxt.retx = scale(st_r.ctrl[`B_RETX_SP] ? st_r.spa : pv, st_r.retx_rng[15:0], st_r.retx_rng[31:16],
                        st_r.ctrl[`B_RETX_420]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.blk <= {NALM{3'(BLK_IDLE)}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign alarm_out = st_r.outv;
  assign alarm_lamp = st_r.lamp;
  assign mv1_out = st_r.mv1;
  assign mv2_out = st_r.mv2;
  assign loop_break_out = st_r.lb;
  assign loop_break_flag = st_r.lb;
  assign display_stop = st_r.dstop;
  assign sp_active = st_r.spa;
  assign retx_code = st_r.retx;

  chk_run_off_alarms: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> alarm_out == '0) else $error("alarm out while stopped");
  chk_run_off_power: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> mv1_out == 10'd0 && mv2_out == 10'd0) else $error("power while stopped");
  chk_lamp_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    alarm_cond[0] |=> alarm_lamp[0]) else $error("lamp not lit");
  chk_safe_value: assert property (@(posedge hclk) disable iff (!hresetn)
    run && sensor_fail |=> mv1_out == $past(st_r.safe)) else $error("safe value not applied");
  chk_loop_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.loop_min == 16'h0000 |=> !loop_break_out) else $error("loop-break while disabled");
  chk_remote_sp: assert property (@(posedge hclk) disable iff (!hresetn)
    remote_setpoint_select_input |=> sp_active == $past(sp_remote)) else $error("remote sp not used");
  chk_follow_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    run && st_r.t1[7:0] == 8'h00 && st_r.t2[7:0] == 8'h00 && st_r.cond_q[0] && alarm_cond[0]
    |=> alarm_out[0]) else $error("follow mode output off");
  chk_manual_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    run && st_r.ctrl[`B_MANUAL] && !sensor_fail && st_r.soft_sec == 16'h0000
    |=> mv1_out == $past(st_r.man1)) else $error("manual power not applied");
endmodule

//--- tb/process_side.sv
`timescale 1ns/1ps
module process_side (
  input  wire logic hclk,
  input  wire logic run_req,
  input  wire logic rsp_req,
  output logic      run_switch_closed,
  output logic      remote_setpoint_select_input
);
  // dry contacts: a closed switch reads high
  initial run_switch_closed = 1'b0;
  initial remote_setpoint_select_input = 1'b0;
  always @(posedge hclk) begin
    run_switch_closed <= run_req;
    remote_setpoint_select_input <= rsp_req;
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "alarm_supervisor_consts.svh"
module tb_top;
  import alarm_supervisor_pkg::*;
  localparam int TC = 20;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hready, hresp, sensor_fail = 1'b0, pv_above_sp = 1'b0, run_req = 1'b0, rsp_req = 1'b0;
  logic        run_sw, rsp_in, loop_break_out, loop_break_flag, display_stop, seen0, seen1;
  logic [3:0]  alarm_cond = 4'h0, alarm_out, alarm_lamp;
  word_t       pv = 16'h0100, sp_main = 16'h0200, sp_remote = 16'h0300, deviation = 16'h0100, sp_active, retx_code;
  pct_t        pid_mv1 = 10'h123, prop_mv2 = 10'h0AB, mv1_out, mv2_out;
  int          err_count = 0, n_tests = 0;
  always #2.5 hclk = ~hclk;
  process_side i_far (.hclk(hclk), .run_req(run_req), .rsp_req(rsp_req), .run_switch_closed(run_sw),
    .remote_setpoint_select_input(rsp_in));
  alarm_output_supervisor #(.NALM(4), .TICK_CYC(TC)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .alarm_cond(alarm_cond), .sensor_fail(sensor_fail),
    .run_switch_closed(run_sw), .remote_setpoint_select_input(rsp_in), .pv(pv), .sp_main(sp_main),
    .sp_remote(sp_remote), .pid_mv1(pid_mv1), .prop_mv2(prop_mv2), .pv_above_sp(pv_above_sp),
    .deviation(deviation), .alarm_out(alarm_out), .alarm_lamp(alarm_lamp), .mv1_out(mv1_out),
    .mv2_out(mv2_out), .loop_break_out(loop_break_out), .loop_break_flag(loop_break_flag),
    .display_stop(display_stop), .sp_active(sp_active), .retx_code(retx_code));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one transfer: address phase held until hready, then data phase held until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    wait_cyc(2);
  endtask
  task automatic t_regs();
    ahb(1'b0, `A_CTRL, 32'h0, rd);
    check("ctrl reset", rd, 32'h0);
    check("hresp okay", hresp, 1'b0);
    ahb(1'b0, 8'h3C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wr(`A_T1, 32'h0000_0012);
    ahb(1'b0, `A_T1, 32'h0, rd);
    check("t1 readback", rd, 32'h0000_0012);
    wr(`A_T1, 32'h0);
  endtask
  task automatic t_stop();
    run_req <= 1'b1;
    alarm_cond <= 4'h1;
    seen0 = 1'b0;
    seen1 = 1'b0;
    wait_cyc(3);
    check("lamp raw", alarm_lamp, 4'h1);
    // stop indication alternates, so both levels show within a few seconds
    repeat (3 * TC) begin
      @(negedge hclk);
      check("out stopped", {alarm_out, 6'h0, mv1_out}, 16'h0);
      if (display_stop === 1'b1) seen1 = 1'b1;
      if (display_stop === 1'b0) seen0 = 1'b1;
    end
    check("stop blink", {seen0, seen1}, 2'h3);
  endtask
  task automatic t_follow();
    wr(`A_CTRL, 32'h1);
    wait_cyc(3);
    check("follow on", alarm_out, 4'h1);
    run_req <= 1'b0;
    wait_cyc(4);
    check("switch open", alarm_out, 4'h0);
    run_req <= 1'b1;
    alarm_cond <= 4'h0;
    wait_cyc(4);
    check("follow off", alarm_out, 4'h0);
  endtask
  task automatic t_pulse();
    wr(`A_T1, 32'h1);
    alarm_cond <= 4'h1;
    wait_cyc(4);
    check("pulse start", alarm_out, 4'h1);
    wait_cyc(30 * TC);
    check("pulse end", alarm_out, 4'h0);
    check("lamp held", alarm_lamp, 4'h1);
    alarm_cond <= 4'h0;
    wr(`A_T1, 32'h0);
  endtask
  task automatic t_power();
    // positive overlap wider than the deviation: both outputs act
    pv_above_sp <= 1'b1;
    wr(`A_BAND, 32'h0200_0064);
    check("mv1 auto", mv1_out, pid_mv1);
    check("mv2 prop", mv2_out, prop_mv2);
    pv_above_sp <= 1'b0;
    wr(`A_BAND, 32'h0);
    check("onoff low", mv1_out, `PCT_FULL);
    check("no cool at zero overlap", mv2_out, 10'h000);
    pv_above_sp <= 1'b1;
    wait_cyc(3);
    check("onoff high", mv1_out, 10'h000);
    check("lbd off", {loop_break_out, loop_break_flag}, 2'h0);
    wr(`A_MAN, 32'h0000_012C);
    wr(`A_CTRL, 32'h3);
    check("manual", mv1_out, 10'h12C);
    wr(`A_SAFE, 32'h0000_01C2);
    sensor_fail <= 1'b1;
    wait_cyc(3);
    check("safe mv1", mv1_out, 10'h1C2);
    wr(`A_SAFE, 32'h0);
    check("safe off", mv1_out, 10'h000);
    sensor_fail <= 1'b0;
  endtask
  task automatic t_rsp();
    rsp_req <= 1'b1;
    wait_cyc(4);
    check("rsp input", sp_active, sp_remote);
    rsp_req <= 1'b0;
    wait_cyc(4);
    check("main sp", sp_active, sp_main);
    wr(`A_CTRL, 32'h5);
    check("rsp param", sp_active, sp_remote);
    wr(`A_RETX, 32'h0200_0000);
    wr(`A_CTRL, 32'h1);
    check("retx pv 0-20", retx_code, 16'h7FFF);
    wr(`A_CTRL, 32'h11);
    check("retx pv 4-20", retx_code, 16'h9999);
    wr(`A_CTRL, 32'h9);
    check("retx sp top", retx_code, 16'hFFFF);
  endtask
  task automatic t_block();
    @(posedge hclk);
    hresetn <= 1'b0;
    alarm_cond <= 4'h3;
    wait_cyc(2);
    hresetn <= 1'b1;
    wait_cyc(2);
    wr(`A_CTRL, 32'h0000_1301);
    wait_cyc(2);
    check("blocked", alarm_out, 4'h1);
    check("lamp blocked", alarm_lamp, 4'h3);
    alarm_cond <= 4'h1;
    wait_cyc(3);
    alarm_cond <= 4'h3;
    wait_cyc(3);
    check("rearmed", alarm_out, 4'h3);
  endtask
  initial begin
    #(5 * 20000);
    err_count++;
    end_of_test();
  end
  initial begin
    wait_cyc(5);
    hresetn <= 1'b1;
    t_regs();
    t_stop();
    t_follow();
    t_pulse();
    t_power();
    t_rsp();
    t_block();
    end_of_test();
  end
endmodule
